// ===== logic/bmsd_top.sv
`timescale 1ns/10ps
module bmsd_top
#(
    parameter int NUM_PINS = 256
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [bmsd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic debug_attached,
    input wire logic [31:0] z1_pin_cfg,
    input wire logic [31:0] z2_pin_cfg,
    input wire logic [31:0] z1_tab_lo,
    input wire logic [31:0] z1_tab_hi,
    input wire logic [31:0] z2_tab_lo,
    input wire logic [31:0] z2_tab_hi,
    input wire logic [NUM_PINS-1:0] gpio_in,
    output logic boot_done,
    output logic [3:0] boot_mode,
    output logic [3:0] boot_opts,
    output logic [2:0] boot_index,
    output logic [3:0] table_entries,
    output logic mode_fallback
);
    import bmsd_pkg::*;

    // =========================================================
    // state
    bmsd_state_t state_q, state_d;
    logic [31:0] emu_pin_q, emu_lo_q, emu_hi_q;
    logic [ANA_W-1:0] ana_sel_q;
    logic [7:0] pin0_q, pin1_q, pin2_q;
    logic en0_q, en1_q, en2_q;
    logic [63:0] table_q;
    logic [1:0] src_q;
    logic [2:0] idx_q;
    logic [3:0] mode_q, opt_q, ent_q;
    logic done_q, fb_q;
    logic [31:0] rdata_q;

    // =========================================================
    // helpers
    function automatic logic [8:0] resolve_sel(input logic [7:0] f,
                                               input logic [7:0] dpin,
                                               input logic den);
        if (f == SEL_OFF)
            resolve_sel = {1'b0, SEL_OFF};
        else if (pin_valid(f))
            resolve_sel = {1'b1, f};
        else
            resolve_sel = {den, dpin};
    endfunction

    function automatic logic is_analog(input logic [7:0] p);
        is_analog = (p >= ANA_LO) && (p <= ANA_HI);
    endfunction

    // analog pin reads low until its digital bit is set
    function automatic logic pin_level(input logic [7:0] p,
                                       input logic [NUM_PINS-1:0] g,
                                       input logic [ANA_W-1:0] a);
        logic [7:0] off;
        off = p - ANA_LO;
        pin_level = g[p] && (!is_analog(p) || a[off[4:0]]);
    endfunction

    // =========================================================
    // source selection: emulation, then zone 2, then zone 1
    wire use_emu_w = debug_attached;
    wire z2_cfgd_w = z2_pin_cfg[KEY_MSB:KEY_LSB] == KEY_VALID;
    wire use_z2_w = !use_emu_w && z2_cfgd_w;
    wire [31:0] cfg_w = use_emu_w ? emu_pin_q :
                        use_z2_w ? z2_pin_cfg : z1_pin_cfg;
    // tables follow the same source as the config word
    wire [63:0] otp_tab_w = use_emu_w ? {emu_hi_q, emu_lo_q} :
                            use_z2_w ? {z2_tab_hi, z2_tab_lo} :
                            {z1_tab_hi, z1_tab_lo};
    wire key_ok_w = cfg_w[KEY_MSB:KEY_LSB] == KEY_VALID;
    wire [7:0] f0_w = cfg_w[SP0_LSB +: FIELD_W];
    wire [7:0] f1_w = cfg_w[SP1_LSB +: FIELD_W];
    wire [7:0] f2_w = cfg_w[SP2_LSB +: FIELD_W];

    // bad key drops every field in favour of factory pins
    wire [8:0] r0_w = key_ok_w ? resolve_sel(f0_w, DEF_PIN0, 1'b1) :
                      {1'b1, DEF_PIN0};
    wire [8:0] r1_w = key_ok_w ? resolve_sel(f1_w, DEF_PIN1, 1'b1) :
                      {1'b1, DEF_PIN1};
    wire [8:0] r2_w = key_ok_w ? resolve_sel(f2_w, SEL_OFF, 1'b0) :
                      {1'b0, SEL_OFF};
    wire [63:0] tab_w = key_ok_w ? otp_tab_w : FACTORY_TABLE;
    wire [1:0] src_w = !key_ok_w ? SRC_FACTORY :
                       use_emu_w ? SRC_EMU :
                       use_z2_w ? SRC_Z2 : SRC_Z1;

    // =========================================================
    // index sampling, disabled pins forced to zero
    wire lvl0_w = en0_q && pin_level(pin0_q, gpio_in, ana_sel_q);
    wire lvl1_w = en1_q && pin_level(pin1_q, gpio_in, ana_sel_q);
    wire lvl2_w = en2_q && pin_level(pin2_q, gpio_in, ana_sel_q);
    wire [2:0] idx_d = {lvl2_w, lvl1_w, lvl0_w};
    wire [1:0] n_en_w = {1'b0, en0_q} + {1'b0, en1_q} + {1'b0, en2_q};
    wire [3:0] ent_d = 4'h1 << n_en_w;

    // =========================================================
    // entry fetch and mode decode
    wire [7:0] entry_w = table_q[{idx_q, 3'b000} +: 8];
    wire [3:0] ent_mode_w = entry_w[3:0];
    wire [3:0] ent_opt_w = entry_w[7:4];
    wire sup_w = mode_supported(ent_mode_w);
    wire [3:0] fb_mode_w = debug_attached ? MODE_WAIT : MODE_FLASH;
    wire [3:0] mode_d = sup_w ? ent_mode_w : fb_mode_w;

    // =========================================================
    // register bus decode
    wire go_w = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO_BIT];
    wire wr_pin_w = reg_wr && reg_addr == REG_EMU_PIN;
    wire wr_lo_w = reg_wr && reg_addr == REG_EMU_LO;
    wire wr_hi_w = reg_wr && reg_addr == REG_EMU_HI;
    wire wr_ana_w = reg_wr && reg_addr == REG_ANA_SEL;
    wire [31:0] status_w = {7'h00, fb_q, 2'h0, src_q, ent_q,
                            1'b0, idx_q, opt_q, mode_q, 3'h0, done_q};
    wire [31:0] ana_rd_w = {{(32-ANA_W){1'b0}}, ana_sel_q};
    // unmapped addresses read as zero
    wire [31:0] rd_mux_w = reg_addr == REG_STATUS ? status_w :
                           reg_addr == REG_EMU_PIN ? emu_pin_q :
                           reg_addr == REG_EMU_LO ? emu_lo_q :
                           reg_addr == REG_EMU_HI ? emu_hi_q :
                           reg_addr == REG_ANA_SEL ? ana_rd_w :
                           reg_addr == REG_TABLE_LO ? table_q[31:0] :
                           reg_addr == REG_TABLE_HI ? table_q[63:32] :
                           RST_WORD;

    // =========================================================
    // sequencer: one pass per reset, then parked in done
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (go_w)
                    state_d = ST_RESOLVE;
            end
            ST_RESOLVE: state_d = ST_SAMPLE;
            ST_SAMPLE: state_d = ST_FETCH;
            ST_FETCH: state_d = ST_DONE;
            ST_DONE: state_d = ST_DONE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // software-writable emulation words and analog select bits
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            emu_pin_q <= RST_WORD;
            emu_lo_q <= RST_WORD;
            emu_hi_q <= RST_WORD;
            ana_sel_q <= '0;
        end
        else
        begin
            if (wr_pin_w)
                emu_pin_q <= reg_wdata;
            if (wr_lo_w)
                emu_lo_q <= reg_wdata;
            if (wr_hi_w)
                emu_hi_q <= reg_wdata;
            if (wr_ana_w)
                ana_sel_q <= reg_wdata[ANA_W-1:0];
        end
    end

    // latch the resolved select pins and table once
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            {en0_q, pin0_q} <= {1'b1, DEF_PIN0};
            {en1_q, pin1_q} <= {1'b1, DEF_PIN1};
            {en2_q, pin2_q} <= {1'b0, SEL_OFF};
            table_q <= FACTORY_TABLE;
            src_q <= SRC_FACTORY;
        end
        else if (state_q == ST_RESOLVE)
        begin
            {en0_q, pin0_q} <= r0_w;
            {en1_q, pin1_q} <= r1_w;
            {en2_q, pin2_q} <= r2_w;
            table_q <= tab_w;
            src_q <= src_w;
        end
    end

    // pins sampled in one cycle only, so later toggles are ignored
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            idx_q <= 3'h0;
            ent_q <= 4'h1;
        end
        else if (state_q == ST_SAMPLE)
        begin
            idx_q <= idx_d;
            ent_q <= ent_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            mode_q <= MODE_PARALLEL;
            opt_q <= 4'h0;
            fb_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (state_q == ST_FETCH)
        begin
            mode_q <= mode_d;
            opt_q <= ent_opt_w;
            fb_q <= !sup_w;
            done_q <= 1'b1;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rdata_q <= RST_WORD;
        else
            rdata_q <= reg_rd ? rd_mux_w : RST_WORD;
    end

    assign reg_rdata = rdata_q;
    assign boot_done = done_q;
    assign boot_mode = mode_q;
    assign boot_opts = opt_q;
    assign boot_index = idx_q;
    assign table_entries = ent_q;
    assign mode_fallback = fb_q;

    // =========================================================
    // checks
    property p_done_hold;
        @(posedge mclk) disable iff (sys_rst)
        boot_done |=> boot_done && $stable(boot_mode) &&
                      $stable(boot_index) && $stable(boot_opts);
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("results moved after done");

    property p_go_latency;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_IDLE && go_w) |-> !boot_done ##4 boot_done;
    endproperty
    a_go_latency: assert property (p_go_latency)
        else $error("done not four cycles after start");

    property p_bad_key;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RESOLVE && !key_ok_w) |=>
            pin0_q == DEF_PIN0 && pin1_q == DEF_PIN1 && !en2_q &&
            table_q == FACTORY_TABLE;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key did not fall back to factory pins");

    property p_all_off;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RESOLVE && key_ok_w && f0_w == SEL_OFF &&
         f1_w == SEL_OFF && f2_w == SEL_OFF) |=> ##1
            idx_q == 3'h0 && table_entries == 4'h1;
    endproperty
    a_all_off: assert property (p_all_off)
        else $error("all select pins off but index not zero");

    property p_sp2_bad;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RESOLVE && key_ok_w && !pin_valid(f2_w)) |=>
            !en2_q;
    endproperty
    a_sp2_bad: assert property (p_sp2_bad)
        else $error("invalid select pin 2 left enabled");

    property p_off_zero;
        @(posedge mclk) disable iff (sys_rst)
        state_q == ST_FETCH |->
            (en0_q || !idx_q[0]) && (en1_q || !idx_q[1]) &&
            (en2_q || !idx_q[2]);
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("disabled select pin set an index bit");

    property p_fallback;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_FETCH && !sup_w) |=>
            boot_mode == $past(fb_mode_w) && mode_fallback;
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("unsupported mode not replaced");

    property p_entry;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_FETCH && sup_w) |=>
            {boot_opts, boot_mode} == table_q[{boot_index, 3'b000} +: 8];
    endproperty
    a_entry: assert property (p_entry)
        else $error("mode and options not from selected byte");

    property p_analog;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_SAMPLE && is_analog(pin0_q) &&
         !ana_sel_q[5'(pin0_q - ANA_LO)]) |=> !boot_index[0];
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog pin sampled without digital select");

    // a bad pin on select 0 must land on its default pin, still enabled
    property p_sp0_bad;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RESOLVE && key_ok_w && f0_w != SEL_OFF &&
         !pin_valid(f0_w)) |=> en0_q && pin0_q == DEF_PIN0;
    endproperty
    a_sp0_bad: assert property (p_sp0_bad)
        else $error("invalid select pin 0 not sent to default");

    // standalone with a keyed zone 2 word must pick the zone 2 source
    property p_z2_wins;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RESOLVE && !debug_attached &&
         z2_pin_cfg[KEY_MSB:KEY_LSB] == KEY_VALID) |=> src_q == SRC_Z2;
    endproperty
    a_z2_wins: assert property (p_z2_wins)
        else $error("keyed zone 2 word did not win over zone 1");

endmodule // bmsd_top

// ===== logic/bmsd_pkg.sv
// Contract
// - analog pins 224-253 read as select only when their digital bit is set
// - pins 14-15,25-27,30,31,34,38,42-58,62-223 are not usable select pins
// - select pin 2 defaults to 0xFF, so it is off by default
// - key other than 0x5A: ignore all fields, use factory select pins
// - valid key with all fields 0xFF: sample nothing, use entry 0
// - index built only from enabled select pins on usable pins
// - bad pin on select 0 or 1 falls back to its default pin
// - bad pin on select pin 2 disables it
// - select pin 0 is index bit 0, pin 2 is bit 2
// - a disabled select pin gives zero in its index bit
// - table is 64 bits, a low word and a high word
// - with a debugger attached the table comes from emulation words
// - usable entries equal two to the power of enabled pins
// - zone 2 configured: table read from zone 2 words
// - entry n sits in byte n of the table
// - entry bits 3:0 give mode, bits 7:4 give options
// - unsupported mode: wait boot with debugger, flash boot standalone
// - config word honoured only with key 0x5A in bits 31:24
// - select fields: pin 2 at 23:16, pin 1 at 15:8, pin 0 at 7:0
// - modes: 0 parallel,1 serial,2 CAN,3 flash,4 wait,5 RAM,6 SPI,7 I2C,10
// - zone 2 config, when programmed, overrides zone 1
package bmsd_pkg;

    // =========================================================
    // config word layout
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 24;
    localparam int SP2_LSB = 16;
    localparam int SP1_LSB = 8;
    localparam int SP0_LSB = 0;
    localparam int FIELD_W = 8;
    localparam logic [7:0] KEY_VALID = 8'h5A;
    localparam logic [7:0] SEL_OFF = 8'hFF;
    localparam logic [7:0] DEF_PIN0 = 8'h20;
    localparam logic [7:0] DEF_PIN1 = 8'h18;
    localparam logic [7:0] ANA_LO = 8'hE0;
    localparam logic [7:0] ANA_HI = 8'hFD;
    localparam int ANA_W = 30;

    // =========================================================
    // boot modes and factory table
    localparam logic [3:0] MODE_PARALLEL = 4'h0;
    localparam logic [3:0] MODE_SERIAL = 4'h1;
    localparam logic [3:0] MODE_CAN = 4'h2;
    localparam logic [3:0] MODE_FLASH = 4'h3;
    localparam logic [3:0] MODE_WAIT = 4'h4;
    localparam logic [3:0] MODE_RAM = 4'h5;
    localparam logic [3:0] MODE_SPI = 4'h6;
    localparam logic [3:0] MODE_I2C = 4'h7;
    localparam logic [3:0] MODE_SEC_FLASH = 4'hA;
    localparam logic [63:0] FACTORY_TABLE = 64'h0000_0000_0302_0100;

    // =========================================================
    // register map and status layout
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EMU_PIN = 8'h08;
    localparam logic [7:0] REG_EMU_LO = 8'h0C;
    localparam logic [7:0] REG_EMU_HI = 8'h10;
    localparam logic [7:0] REG_ANA_SEL = 8'h14;
    localparam logic [7:0] REG_TABLE_LO = 8'h18;
    localparam logic [7:0] REG_TABLE_HI = 8'h1C;
    localparam int CTRL_GO_BIT = 0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] SRC_Z1 = 2'h0;
    localparam logic [1:0] SRC_Z2 = 2'h1;
    localparam logic [1:0] SRC_EMU = 2'h2;
    localparam logic [1:0] SRC_FACTORY = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RESOLVE = 5'h02,
        ST_SAMPLE = 5'h04,
        ST_FETCH = 5'h08,
        ST_DONE = 5'h10
    } bmsd_state_t;

    // =========================================================
    // pin number usable as a select pin
    function automatic logic pin_valid(input logic [7:0] p);
        pin_valid = !((p >= 8'h0E && p <= 8'h0F) ||
                      (p >= 8'h19 && p <= 8'h1B) ||
                      p == 8'h1E || p == 8'h1F ||
                      p == 8'h22 || p == 8'h26 ||
                      (p >= 8'h2A && p <= 8'h3A) ||
                      (p >= 8'h3E && p <= 8'hDF));
    endfunction

    function automatic logic mode_supported(input logic [3:0] m);
        mode_supported = (m <= MODE_I2C) || (m == MODE_SEC_FLASH);
    endfunction

endpackage

// ===== verification/bmsd_pins.sv
`timescale 1ns/10ps
// =====================================================================
// configuration store and pin model for the boot select decoder
module bmsd_pins
(
    input wire logic mclk,
    output logic [31:0] z1_pin_cfg,
    output logic [31:0] z2_pin_cfg,
    output logic [31:0] z1_tab_lo,
    output logic [31:0] z1_tab_hi,
    output logic [31:0] z2_tab_lo,
    output logic [31:0] z2_tab_hi,
    output logic [255:0] gpio_in
);
    logic [255:0] hold = '0;
    logic [255:0] lvl = '0;
    logic [255:0] noise = 256'hA5C3_0F96_7E18_D24B;

    // erased store reads all ones, so every key starts out invalid
    initial
    begin
        load(32'hFFFF_FFFF, 32'hFFFF_FFFF, '1, '1, '1, '1);
    end

    // select fields at 23:16, 15:8, 7:0 and key at 31:24
    // table kept as a low word and a high word
    // disabling select pins from pin 2 downward is up to the caller
    task automatic load(input logic [31:0] c1, input logic [31:0] c2,
                        input logic [31:0] l1, input logic [31:0] h1,
                        input logic [31:0] l2, input logic [31:0] h2);
        z1_pin_cfg = c1;
        z2_pin_cfg = c2;
        z1_tab_lo = l1;
        z1_tab_hi = h1;
        z2_tab_lo = l2;
        z2_tab_hi = h2;
    endtask

    // pins not held churn every cycle, so a stray sample never looks stable
    always @(posedge mclk)
        noise <= {noise[254:0], noise[255] ^ noise[200]};
    assign gpio_in = (hold & lvl) | (~hold & noise);
endmodule // bmsd_pins

// ===== verification/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end

module testbench;
    import bmsd_pkg::*;
    localparam logic [31:0] TLO = 32'h2766_2403;
    localparam logic [31:0] THI = 32'hB845_A302;
    localparam logic [255:0] ONE = 256'h1;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic debug_attached = 1'b0;
    wire [31:0] reg_rdata, z1c, z2c, z1l, z1h, z2l, z2h;
    wire [255:0] gpio_in;
    wire boot_done, mode_fallback;
    wire [3:0] boot_mode, boot_opts, table_entries;
    wire [2:0] boot_index;
    int n_fail = 0;
    int cmp_count = 0;

    // =================================================================
    // clock, partner and design
    always #5 mclk = ~mclk;

    bmsd_pins store(.mclk(mclk), .z1_pin_cfg(z1c), .z2_pin_cfg(z2c),
        .z1_tab_lo(z1l), .z1_tab_hi(z1h), .z2_tab_lo(z2l),
        .z2_tab_hi(z2h), .gpio_in(gpio_in));

    bmsd_top #(.NUM_PINS(256)) dut(.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .debug_attached(debug_attached), .z1_pin_cfg(z1c),
        .z2_pin_cfg(z2c), .z1_tab_lo(z1l), .z1_tab_hi(z1h),
        .z2_tab_lo(z2l), .z2_tab_hi(z2h), .gpio_in(gpio_in),
        .boot_done(boot_done), .boot_mode(boot_mode),
        .boot_opts(boot_opts), .boot_index(boot_index),
        .table_entries(table_entries), .mode_fallback(mode_fallback));

    // =================================================================
    // bus and sequencing tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask

    task automatic rst(input logic dbg);
        @(posedge mclk);
        sys_rst <= 1'b1;
        debug_attached <= dbg;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one boot pass; expectation built from the table and mode list
    task automatic run(input logic [2:0] ix, input logic [3:0] en,
                       input logic [1:0] src, input logic [63:0] tab,
                       input logic dbg);
        logic [7:0] e;
        logic [3:0] xm;
        logic ok;
        logic [31:0] st;
        int n;
        e = tab[ix*8 +: 8];
        ok = (e[3:0] <= 4'h7) || (e[3:0] == 4'hA);
        xm = ok ? e[3:0] : (dbg ? 4'h4 : 4'h3);
        st = 32'h0;
        st[0] = 1'b1;
        st[7:4] = xm;
        st[11:8] = e[7:4];
        st[14:12] = ix;
        st[19:16] = en;
        st[21:20] = src;
        st[24] = ~ok;
        n = 0;
        wr(REG_CTRL, 32'h1);
        while (boot_done !== 1'b1 && n < 10)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 10)
        begin
            n_fail++;
            finish_test();
        end
        `CHK("latency", 3, n)
        `CHK("index", ix, boot_index)
        `CHK("entries", en, table_entries)
        `CHK("mode", xm, boot_mode)
        `CHK("opts", e[7:4], boot_opts)
        `CHK("fallback", ~ok, mode_fallback)
        rd(REG_STATUS, st, "status");
        rd(REG_TABLE_LO, tab[31:0], "tab_lo");
        rd(REG_TABLE_HI, tab[63:32], "tab_hi");
    endtask

    // =================================================================
    // scenarios
    initial
    begin
        rst(1'b0);
        `CHK("rst_entries", 4'h1, table_entries)
        `CHK("rst_done", 1'b0, boot_done)
        // bad key: factory pins 32 and 24, pin 2 off
        store.load(32'h0000_0000, '1, TLO, THI, '1, '1);
        store.hold = '1;
        store.lvl = (ONE << 32) | (ONE << 24);
        rst(1'b0);
        run(3'd3, 4'd4, SRC_FACTORY, FACTORY_TABLE, 1'b0);
        // all fields off: entry 0 whatever the pins
        store.load(32'h5AFF_FFFF, '1, TLO, THI, '1, '1);
        store.lvl = '1;
        rst(1'b0);
        run(3'd0, 4'd1, SRC_Z1, {THI, TLO}, 1'b0);
        // select pins 0 and 2 only, pin 1 gives zero
        store.load(32'h5A07_FF05, '1, TLO, THI, '1, '1);
        store.hold = (ONE << 5) | (ONE << 7);
        store.lvl = store.hold;
        rst(1'b0);
        run(3'd5, 4'd4, SRC_Z1, {THI, TLO}, 1'b0);
        // pin 14 on select 0 goes to 32, pin 200 on select 2 disables it
        store.load(32'h5AC8_010E, '1, TLO, THI, '1, '1);
        store.hold = '1;
        store.lvl = (ONE << 32) | (ONE << 1) | (ONE << 200) | (ONE << 14);
        rst(1'b0);
        run(3'd3, 4'd4, SRC_Z1, {THI, TLO}, 1'b0);
        // zone 2 word and table win over zone 1
        store.load(32'h5AFF_FFFF, 32'h5AFF_FF00, TLO, THI, 32'h1605, '0);
        store.lvl = ONE;
        rst(1'b0);
        run(3'd1, 4'd2, SRC_Z2, {32'h0, 32'h1605}, 1'b0);
        // debugger: emulation words, unsupported mode 8 -> wait
        store.load(32'h5AFF_FFFF, '1, '0, '0, '1, '1);
        store.lvl = '1;
        rst(1'b1);
        wr(REG_EMU_PIN, 32'h5A02_0100);
        wr(REG_EMU_LO, TLO);
        wr(REG_EMU_HI, THI);
        rd(REG_EMU_LO, TLO, "emu_lo");
        run(3'd7, 4'd8, SRC_EMU, {THI, TLO}, 1'b1);
        // standalone: same entry falls back to flash
        store.load(32'h5A02_0100, '1, TLO, THI, '1, '1);
        rst(1'b0);
        run(3'd7, 4'd8, SRC_Z1, {THI, TLO}, 1'b0);
        // secure flash entry is kept as is, no fallback
        store.load(32'h5AFF_FFFF, '1, 32'h0000_002A, '0, '1, '1);
        rst(1'b0);
        run(3'd0, 4'd1, SRC_Z1, {32'h0, 32'h2A}, 1'b0);
        // analog pin 230 reads zero until its digital bit is set
        store.load(32'h5AFF_FFE6, '1, TLO, THI, '1, '1);
        store.lvl = ONE << 230;
        rst(1'b0);
        run(3'd0, 4'd2, SRC_Z1, {THI, TLO}, 1'b0);
        rst(1'b0);
        wr(REG_ANA_SEL, 32'h0000_0040);
        rd(REG_ANA_SEL, 32'h0000_0040, "ana_sel");
        run(3'd1, 4'd2, SRC_Z1, {THI, TLO}, 1'b0);
        // results hold: pins drop and a second go is ignored
        store.lvl = '0;
        wr(REG_CTRL, 32'h1);
        repeat (6) @(posedge mclk);
        #1;
        `CHK("held_index", 3'd1, boot_index)
        `CHK("held_done", 1'b1, boot_done)
        rd(8'h20, 32'h0, "unmapped");
        rd(REG_CTRL, 32'h0, "ctrl");
        finish_test();
    end
endmodule // testbench
